/* inc/ddrs_consts.svh */
// Constants for the double-data-rate burst SRAM port
`ifndef DDRS_CONSTS_SVH
`define DDRS_CONSTS_SVH

// ==========================================================
// Organisation
`define DDRS_ADDR_W 20
`define DDRS_BYTE_W 9
`define DDRS_NBYTE 2
`define DDRS_DATA_W (`DDRS_BYTE_W * `DDRS_NBYTE)
`define DDRS_BURST_W 2

// ==========================================================
// Timing: DDRS_CLK_NS in ns, DDRS_CMD_DELAY in half-periods of the input clock pair (one clk_sys cycle each)
`define DDRS_CLK_NS 10
`define DDRS_CMD_DELAY 2
`define DDRS_FIFO_DEPTH 4

// ==========================================================
// Reset values
`define DDRS_OE_N_RST 1'b1
`define DDRS_IDX_RST 2'h0

`endif

/* inc/ddrs_pkg.sv */
// Types for the double-data-rate burst SRAM port
package ddrs_pkg;
   typedef enum logic [1:0] {
      DDRS_ENG_IDLE,
      DDRS_ENG_WRITE,
      DDRS_ENG_READ
   } ddrs_eng_type;
endpackage

/* hdl/ddrs_store.sv */
// Word FIFO and byte-writable memory array used by the burst SRAM port
`timescale 1ns/1ps

// ==========================================================
// FIFO with valid/ready on both sides
module ddrs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 4
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [PW-1:0] wp_q;
   logic [PW-1:0] rp_q;
   logic [PW:0] cnt_q;
   wire push = in_valid && in_ready;
   wire pop = out_valid && out_ready;

   assign in_ready = (cnt_q != (PW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign out_data = mem_q[rp_q];

   always_ff @(posedge clk_sys) begin
      if (push) begin
         mem_q[wp_q] <= in_data;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         wp_q <= '0;
         rp_q <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wp_q <= (wp_q == PW'(DEPTH - 1)) ? '0 : PW'(wp_q + 1'b1);
         end
         if (pop) begin
            rp_q <= (rp_q == PW'(DEPTH - 1)) ? '0 : PW'(rp_q + 1'b1);
         end
         cnt_q <= PW'(0) + cnt_q + (PW+1)'(push) - (PW+1)'(pop);
      end
   end
endmodule

// ==========================================================
// Single-port array, per-lane write enables, registered read data
module ddrs_mem #(
   parameter int AW = 20,
   parameter int BW = 9,
   parameter int NB = 2
) (
   input wire logic clk_sys,
   input wire logic [AW-1:0] addr,
   input wire logic wr_en,
   input wire logic [NB-1:0] wr_sel_n,
   input wire logic [BW*NB-1:0] wr_data,
   input wire logic rd_en,
   output logic [BW*NB-1:0] rd_data
);
   genvar g;
   generate
      for (g = 0; g < NB; g++) begin : g_lane
         // Each lane owns its read register, so no flop is written by two processes
         logic [BW-1:0] arr [2**AW];
         logic [BW-1:0] lane_rd_q;
         assign rd_data[g*BW +: BW] = lane_rd_q;
         always_ff @(posedge clk_sys) begin
            // A deselected lane keeps its stored byte
            if (wr_en && !wr_sel_n[g]) begin
               arr[addr] <= wr_data[g*BW +: BW];
            end
            if (rd_en) begin
               lane_rd_q <= arr[addr];
            end
         end
      end
   endgenerate
endmodule

/* hdl/ddrs_port.sv */
// Command, burst and byte-write logic of a DDR burst SRAM port
`timescale 1ns/1ps
`include "ddrs_consts.svh"

// Summary of operation
// - Write command at K rise t; four words taken at K and K# rises of t+1, t+2.
// - Read command at t; words driven at C# t+1, C and C# t+2, C t+3.
// - After power-up the port is deselected and data pins are high impedance.
// - First burst word uses the captured address; the other three are generated.
// - Burst counter steps only the two low address bits, wrapping 11 to 00.
// - Write data is registered on both the positive and negative input clock rises.
// - Read data launches on output clock rises, or input clock rises in strap mode; the code launches on every clk_sys edge in both modes.
// - 18-bit: select 0 writes bits 8..0, select 1 bits 17..9; others unchanged.
// - 18-bit: both selects high on a data edge writes nothing for that word.
// - 36-bit: selects 0..3 enable bytes 8..0, 17..9, 26..18, 35..27 individually.
// - 36-bit: all four selects high on a data edge writes nothing.
// - Byte selects are sampled per data edge and apply to that word only.
// - Command on the K rise right after an accepted command is ignored.
module ddrs_port
   import ddrs_pkg::*;
(
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic k_pos,
   input wire logic load_strobe_n,
   input wire logic rd_not_wr,
   input wire logic [`DDRS_ADDR_W-1:0] addr,
   input wire logic [`DDRS_NBYTE-1:0] byte_write_select_n,
   input wire logic [`DDRS_DATA_W-1:0] dq_in,
   output logic [`DDRS_DATA_W-1:0] dq_out,
   output logic dq_oe_n,
   input wire logic single_clock_strap,
   output logic single_clock_mode,
   output logic cmd_refused
);
   localparam int AW = `DDRS_ADDR_W;
   localparam int DW = `DDRS_DATA_W;
   localparam int NB = `DDRS_NBYTE;
   localparam int BW = `DDRS_BYTE_W;
   localparam int FW = AW + NB + DW;

   // ==========================================================
   // Strap capture
   // The strap is a board pin, so two flip-flops bring it into clk_sys first
   logic strap_meta_q;
   logic strap_sync_q;
   logic strap_q;
   logic strap_d;

   always_ff @(posedge clk_sys) begin
      strap_meta_q <= single_clock_strap;
   end

   always_ff @(posedge clk_sys) begin
      strap_sync_q <= strap_meta_q;
   end

   // The strap is only caught while reset is held; changing it later has no effect
   assign strap_d = rst_n ? strap_q : strap_sync_q;
   always_ff @(posedge clk_sys) begin
      strap_q <= strap_d;
   end
   assign single_clock_mode = strap_q;

   // ==========================================================
   // Command decode
   logic cmd_prev_q;
   logic cmd_prev_d;
   logic fifo_in_ready;
   logic fifo_out_valid;
   wire cmd_seen = k_pos && !load_strobe_n;
   // The FIFO drains a word per edge outside reads, so legal spacing leaves at most
   // one word in it; only a full FIFO refuses a write rather than lose words
   wire wr_blocked = !rd_not_wr && !fifo_in_ready;
   wire cmd_take = cmd_seen && !cmd_prev_q && !wr_blocked;
   wire refuse_d = cmd_seen && !cmd_take;

   always_comb begin
      cmd_prev_d = cmd_prev_q;
      if (k_pos) begin
         cmd_prev_d = cmd_take;
      end
   end

   // Command waits one half-period before its burst starts
   logic s1_valid_q;
   logic s1_read_q;
   logic [AW-1:0] s1_addr_q;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cmd_prev_q <= 1'b0;
         s1_valid_q <= 1'b0;
         cmd_refused <= 1'b0;
      end else begin
         cmd_prev_q <= cmd_prev_d;
         s1_valid_q <= cmd_take;
         cmd_refused <= refuse_d;
      end
   end

   // Direction and address are only read while s1_valid_q is set, so they need no reset
   always_ff @(posedge clk_sys) begin
      s1_read_q <= rd_not_wr;
      s1_addr_q <= addr;
   end

   // ==========================================================
   // Burst engine: four consecutive half-periods starting at K rise t+1
   ddrs_eng_type eng_q;
   ddrs_eng_type eng_d;
   logic [`DDRS_BURST_W-1:0] idx_q;
   logic [`DDRS_BURST_W-1:0] idx_d;
   logic [AW-1:0] base_q;
   logic [AW-1:0] base_d;

   wire last_word = (idx_q == 2'h3);

   always_comb begin
      eng_d = eng_q;
      idx_d = idx_q;
      base_d = base_q;
      if (eng_q != DDRS_ENG_IDLE) begin
         idx_d = 2'(idx_q + 2'h1);
         if (last_word) begin
            eng_d = DDRS_ENG_IDLE;
         end
      end
      // Back-to-back bursts meet exactly: the next one starts as this one ends
      if (s1_valid_q) begin
         eng_d = s1_read_q ? DDRS_ENG_READ : DDRS_ENG_WRITE;
         idx_d = `DDRS_IDX_RST;
         base_d = s1_addr_q;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         eng_q <= DDRS_ENG_IDLE;
         idx_q <= `DDRS_IDX_RST;
         base_q <= '0;
      end else begin
         eng_q <= eng_d;
         idx_q <= idx_d;
         base_q <= base_d;
      end
   end

   // Upper bits fixed, low two bits count with wrap
   logic [`DDRS_BURST_W-1:0] low_addr;
   logic [AW-1:0] burst_addr;
   assign low_addr = 2'(base_q[`DDRS_BURST_W-1:0] + idx_q);
   assign burst_addr = {base_q[AW-1:`DDRS_BURST_W], low_addr};

   wire eng_wr = (eng_q == DDRS_ENG_WRITE);
   wire eng_rd = (eng_q == DDRS_ENG_READ);

   // ==========================================================
   // Write path: one word per half-period into the FIFO
   logic [FW-1:0] fifo_in;
   logic [FW-1:0] fifo_out;
   logic fifo_out_ready;
   // A word with every select high writes nothing, so it never takes a FIFO slot
   wire word_has_lane = (byte_write_select_n != {NB{1'b1}});
   wire fifo_push = eng_wr && word_has_lane && fifo_in_ready;

   // Each word carries its own selects, sampled on its own data edge
   assign fifo_in = {burst_addr, byte_write_select_n, dq_in};

   // Reads own the array while their burst runs; queued writes drain around them
   assign fifo_out_ready = !eng_rd;

   ddrs_fifo #(
      .WIDTH(FW),
      .DEPTH(`DDRS_FIFO_DEPTH)
   ) u_fifo (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .in_valid(fifo_push),
      .in_ready(fifo_in_ready),
      .in_data(fifo_in),
      .out_valid(fifo_out_valid),
      .out_ready(fifo_out_ready),
      .out_data(fifo_out)
   );

   // ==========================================================
   // Array access
   wire [AW-1:0] drain_addr = fifo_out[FW-1 -: AW];
   wire [NB-1:0] drain_sel_n = fifo_out[DW +: NB];
   wire [DW-1:0] drain_data = fifo_out[DW-1:0];
   wire mem_wr = fifo_out_valid && fifo_out_ready;
   wire [AW-1:0] mem_addr = eng_rd ? burst_addr : drain_addr;
   logic [DW-1:0] mem_rd_data;

   // All-high words are dropped before the FIFO, so every drained word enables at least one lane
   ddrs_mem #(
      .AW(AW),
      .BW(`DDRS_BYTE_W),
      .NB(NB)
   ) u_mem (
      .clk_sys(clk_sys),
      .addr(mem_addr),
      .wr_en(mem_wr),
      .wr_sel_n(drain_sel_n),
      .wr_data(drain_data),
      .rd_en(eng_rd),
      .rd_data(mem_rd_data)
   );

   // ==========================================================
   // Read bypass
   // A read that meets a write word still parked in the FIFO would return stale lanes.
   // Only the FIFO head is compared: under legal spacing it is the only word left
   // waiting while a read owns the array.
   wire bypass_hit = eng_rd && fifo_out_valid && (drain_addr == burst_addr);
   logic bypass_q;
   logic [NB-1:0] bypass_sel_n_q;
   logic [DW-1:0] bypass_data_q;
   logic [DW-1:0] read_word;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         bypass_q <= 1'b0;
      end else begin
         bypass_q <= bypass_hit;
      end
   end

   always_ff @(posedge clk_sys) begin
      bypass_sel_n_q <= drain_sel_n;
      bypass_data_q <= drain_data;
   end

   genvar g;
   generate
      for (g = 0; g < NB; g++) begin : g_merge
         assign read_word[g*BW +: BW] = (bypass_q && !bypass_sel_n_q[g]) ?
            bypass_data_q[g*BW +: BW] : mem_rd_data[g*BW +: BW];
      end
   endgenerate

   // ==========================================================
   // Read path
   // The array word is ready one edge after the engine asks for it; a second
   // register launches it, so the first word leaves on the K# rise of t+1
   logic drive_q;
   logic drive_d;
   logic launch_q;
   logic launch_d;
   logic [DW-1:0] dq_q;
   logic [DW-1:0] dq_d;
   assign drive_d = eng_rd;
   assign launch_d = drive_q;
   // Idle data is forced to zero so a floating bus never shows a stale word
   assign dq_d = drive_q ? read_word : '0;

   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         drive_q <= 1'b0;
         launch_q <= 1'b0;
         dq_q <= '0;
      end else begin
         drive_q <= drive_d;
         launch_q <= launch_d;
         dq_q <= dq_d;
      end
   end

   // Every clk_sys edge is a rise of one clock of the pair, so the registered
   // word launches on each of them; in strap mode the pair is K/K#
   assign dq_out = dq_q;
   assign dq_oe_n = launch_q ? 1'b0 : `DDRS_OE_N_RST;

endmodule

/* tb/ddrs_port_checker.sv */
// Port assertions for the burst SRAM port
`timescale 1ns/1ps
module ddrs_port_checker (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic k_pos,
   input wire logic load_strobe_n,
   input wire logic rd_not_wr,
   input wire logic [17:0] dq_out,
   input wire logic dq_oe_n,
   input wire logic single_clock_mode,
   input wire logic cmd_refused
);
   // ==========================================
   // Command decode, read drive window, refusal and strap mode checks
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!rst_n);
   wire any_c = k_pos && !load_strobe_n;
   wire rd_c = any_c && rd_not_wr;
   a_read_window: assert property (rd_c ##1 !cmd_refused |-> ##3 !dq_oe_n [*4]) else $error("late read");
   a_read_end: assert property (rd_c ##1 !cmd_refused ##3 !rd_c |-> ##4 dq_oe_n) else $error("no float");
   a_oe_cause: assert property ($fell(dq_oe_n) |-> $past(rd_c, 4)) else $error("stray drive");
   a_oe_four: assert property ($fell(dq_oe_n) |=> !dq_oe_n [*3]) else $error("short burst");
   a_float_zero: assert property (dq_oe_n |-> dq_out == 18'h0_0000) else $error("idle data");
   a_refuse_b2b: assert property (any_c ##1 !cmd_refused ##1 any_c |=> cmd_refused) else $error("no refuse");
   a_refuse_cause: assert property (cmd_refused |-> $past(any_c)) else $error("stray refuse");
   a_mode_stable: assert property ($stable(single_clock_mode)) else $error("mode moved");
   c_read: cover property (rd_c);
   c_write: cover property (any_c && !rd_not_wr);
   c_refuse: cover property (cmd_refused);
endmodule
bind ddrs_port ddrs_port_checker ddrs_port_checker_inst (.clk_sys(clk_sys), .rst_n(rst_n), .k_pos(k_pos),
   .load_strobe_n(load_strobe_n), .rd_not_wr(rd_not_wr), .dq_out(dq_out), .dq_oe_n(dq_oe_n),
   .single_clock_mode(single_clock_mode), .cmd_refused(cmd_refused));

/* tb/ddrs_ctrl_model.sv */
// Memory controller model: input clock phase, commands, write bursts
`timescale 1ns/1ps
module ddrs_ctrl_model (
   input wire logic clk_sys,
   output logic k_pos = 1'h0,
   output logic load_strobe_n = 1'h1,
   output logic rd_not_wr = 1'h0,
   output logic [19:0] addr = 20'h0_0000,
   output logic [1:0] byte_write_select_n = 2'h3,
   output logic [17:0] dq_in = 18'h0_0000
);
   // The K pair runs free for the whole run and is never parked
   always @(posedge clk_sys) k_pos <= #1 ~k_pos;
   // Only on a K rise, and released lines show the inverse so stale values never pass
   task automatic cmd(input logic rnw, input logic [19:0] a);
      @(posedge clk_sys);
      if (k_pos)
         @(posedge clk_sys);
      #1;
      load_strobe_n = 1'h0;
      rd_not_wr = rnw;
      addr = a;
      @(posedge clk_sys);
      #1;
      load_strobe_n = 1'h1;
      rd_not_wr = ~rnw;
      addr = ~a;
   endtask
   task automatic wr(input logic [19:0] a, input logic [3:0][17:0] d, input logic [3:0][1:0] s);
      cmd(1'h0, a);
      for (int i = 0; i < 4; i++) begin
         @(posedge clk_sys);
         #1;
         dq_in = d[i];
         byte_write_select_n = s[i];
      end
      @(posedge clk_sys);
      #1;
      dq_in = ~dq_in;
      byte_write_select_n = 2'h3;
   endtask
endmodule

/* tb/tb_top.sv */
// Self-checking bench for the burst SRAM port
`timescale 1ns/1ps
module tb_top;
   logic clk_sys = 1'h0;
   logic rst_n = 1'h0;
   logic strap = 1'h1;
   wire k_pos, load_strobe_n, rd_not_wr, dq_oe_n, mode, cmd_refused;
   wire [19:0] addr;
   wire [1:0] byte_write_select_n;
   wire [17:0] dq_in, dq_out;
   int miscompares = 0;
   int comparisons = 0;
   ddrs_port ddrs_port_inst (.clk_sys(clk_sys), .rst_n(rst_n), .k_pos(k_pos), .load_strobe_n(load_strobe_n),
      .rd_not_wr(rd_not_wr), .addr(addr), .byte_write_select_n(byte_write_select_n), .dq_in(dq_in),
      .dq_out(dq_out), .dq_oe_n(dq_oe_n), .single_clock_strap(strap), .single_clock_mode(mode),
      .cmd_refused(cmd_refused));
   ddrs_ctrl_model ddrs_ctrl_model_inst (.clk_sys(clk_sys), .k_pos(k_pos), .load_strobe_n(load_strobe_n),
      .rd_not_wr(rd_not_wr), .addr(addr), .byte_write_select_n(byte_write_select_n), .dq_in(dq_in));
   initial forever #5 clk_sys = ~clk_sys;
   task automatic chk(input logic [17:0] got, input logic [17:0] exp);
      comparisons++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic rd(input logic [19:0] a, output logic [3:0][17:0] q);
      ddrs_ctrl_model_inst.cmd(1'h1, a);
      repeat (3) @(posedge clk_sys);
      #1;
      for (int i = 0; i < 4; i++) begin
         chk(dq_oe_n, 18'h0_0000);
         q[i] = dq_out;
         @(posedge clk_sys);
         #1;
      end
      chk(dq_oe_n, 18'h0_0001);
   endtask
   task automatic t_reset();
      chk(dq_oe_n, 18'h0_0001);
      chk(mode, 18'h0_0001);
      $display("t_reset done");
   endtask
   task automatic t_burst();
      logic [3:0][17:0] d, q;
      d = {18'h3_0c04, 18'h2_0b03, 18'h1_0a02, 18'h0_0901};
      ddrs_ctrl_model_inst.wr(20'h0_1232, d, 8'h00);
      repeat (6) @(posedge clk_sys);
      rd(20'h0_1230, q);
      for (int i = 0; i < 4; i++)
         chk(q[i], d[(i + 2) % 4]);
      $display("t_burst done");
   endtask
   task automatic t_bytes();
      logic [3:0][17:0] q;
      logic [3:0][1:0] s;
      s = {2'h3, 2'h1, 2'h2, 2'h0};
      ddrs_ctrl_model_inst.wr(20'h0_2000, {4{18'h2_aaaa}}, 8'h00);
      repeat (6) @(posedge clk_sys);
      ddrs_ctrl_model_inst.wr(20'h0_2000, {4{18'h1_5555}}, s);
      repeat (6) @(posedge clk_sys);
      rd(20'h0_2000, q);
      for (int i = 0; i < 4; i++)
         chk(q[i], ((s[i][0] ? 18'h2_aaaa : 18'h1_5555) & 18'h0_01ff) |
            ((s[i][1] ? 18'h2_aaaa : 18'h1_5555) & 18'h3_fe00));
      $display("t_bytes done");
   endtask
   task automatic t_refuse();
      ddrs_ctrl_model_inst.cmd(1'h1, 20'h0_1230);
      ddrs_ctrl_model_inst.cmd(1'h1, 20'h0_2000);
      chk(cmd_refused, 18'h0_0001);
      repeat (6) @(posedge clk_sys);
      #1;
      chk(dq_oe_n, 18'h0_0001);
      $display("t_refuse done");
   endtask
   task automatic results();
      $display("comparisons %0d miscompares %0d", comparisons, miscompares);
      if (miscompares == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      #20000;
      miscompares++;
      results();
   end
   initial begin
      repeat (8) @(posedge clk_sys);
      #1;
      rst_n = 1'h1;
      t_reset();
      t_burst();
      t_bytes();
      t_refuse();
      results();
   end
endmodule
